//--- modbus_slave_query_handler.sv
// Modbus slave query handler: parses queries, keeps holding registers,
// answers with normal or exception replies and triggers commands.
// Assumes rx bytes arrive one per rx_valid and rx_end follows the last.
`timescale 1ns/1ps
module modbus_slave_query_handler (
	// Clock and reset.
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	// Own slave address.
	input  wire logic [7:0]  slave_addr,
	// Received bytes from the framing layer.
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_valid,
	input  wire logic        rx_end,
	input  wire logic        rx_err,
	// Reply bytes to the framing layer.
	input  wire logic        tx_ready,
	output logic      [7:0]  tx_data,
	output logic             tx_valid,
	output logic             tx_last,
	// Commands to the instrument.
	output logic             cmd_valid,
	output logic      [15:0] cmd_num,
	// Status.
	output logic             remote_setup,
	output logic             busy
);
	import modbus_query_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		st_t                          st;
		logic [7:0]                   cnt;
		logic [7:0]                   fn;
		logic [15:0]                  start;
		logic [15:0]                  qty;
		logic [7:0]                   bc;
		logic                         first_bit;
		logic [NREG-1:0][15:0]        mem;
		logic [NREG-1:0][15:0]        shd;
		logic [ECHO_LEN-1:0][7:0]     echo;
		logic [7:0]                   exc;
		logic [7:0]                   rlen;
		logic [7:0]                   ridx;
		logic [7:0]                   tx_data;
		logic                         tx_valid;
		logic                         tx_last;
		logic                         cmd_valid;
		logic [15:0]                  cmd_num;
		logic                         remote;
		logic                         busy;
	} state_t;

	localparam logic [NREG-1:0][15:0] MEM_RST =
		{{(NREG - 6){16'h0000}}, {6{SPACE_WORD}}};

	state_t      s;
	state_t      next_s;
	logic [15:0] crc_rx;
	logic [15:0] crc_tx;
	logic [4:0]  m;
	logic [4:0]  w;
	logic [7:0]  j;
	logic [7:0]  code;
	logic [15:0] cause;
	logic [15:0] cmd;
	logic [7:0]  rl;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// Map a register number to {valid, storage index}.
	function automatic logic [4:0] map_reg(input logic [15:0] a);
		logic [4:0] r;
		r = 5'h00;
		if (a >= NAME_BASE && a < NAME_END) begin
			r = {1'b1, 4'(a - NAME_BASE)};
		end else if (a >= SETUP_BASE && a < SETUP_END) begin
			r = {1'b1, 4'(a - SETUP_BASE) + IDX_SETUP};
		end else if (a == CMDERR_ADDR) begin
			r = {1'b1, IDX_CMDERR};
		end
		return r;
	endfunction

	// Byte n of the reply held in the state.
	function automatic logic [7:0] resp_byte(input logic [7:0] n);
		logic [7:0]  b;
		logic [7:0]  k;
		logic [4:0]  a;
		logic [15:0] v;
		k = n - 8'h03;
		a = map_reg(s.start + {9'h000, k[7:1]});
		v = a[4] ? s.mem[a[3:0]] : FILLER;
		b = 8'h00;
		if (n == 8'h00) begin
			b = slave_addr;
		end else if (n == 8'h01) begin
			b = (s.exc != 8'h00) ? (s.fn | EXC_FLAG) : s.fn;
		end else if (s.exc != 8'h00) begin
			b = s.exc;
		end else begin
			case (s.fn)
				FN_RD_COIL, FN_RD_INPUT: begin
					// Every point reads as off.
					b = (n == 8'h02) ? 8'((s.qty + 16'h0007) >> 3) : 8'h00;
				end
				FN_RD_HOLD: begin
					if (n == 8'h02) begin
						b = {s.qty[6:0], 1'b0};
					end else begin
						b = k[0] ? v[7:0] : v[15:8];
					end
				end
				FN_DIAG: begin
					b = s.echo[n - 8'h02];
				end
				default: begin
					case (n)
						8'h02: b = s.start[15:8];
						8'h03: b = s.start[7:0];
						8'h04: b = s.qty[15:8];
						default: b = s.qty[7:0];
					endcase
				end
			endcase
		end
		return b;
	endfunction

	// ------------------------------------------------------------
	// CRC of the received and the transmitted frame
	// ------------------------------------------------------------
	crc16_unit #(.POLY(CRC_POLY), .INIT(CRC_INIT)) u_crc_rx (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.clr     (rx_end || s.st != ST_RX),
		.en      (rx_valid && s.st == ST_RX),
		.din     (rx_data),
		.crc     (crc_rx)
	);

	crc16_unit #(.POLY(CRC_POLY), .INIT(CRC_INIT)) u_crc_tx (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.clr     (s.st == ST_RX),
		.en      (s.st == ST_RESP && s.tx_valid && tx_ready),
		.din     (s.tx_data),
		.crc     (crc_tx)
	);

	// ------------------------------------------------------------
	// Query engine
	// ------------------------------------------------------------

	// Receive, judge, commit and answer one query at a time.
	always_comb begin
		next_s = s;
		next_s.cmd_valid = 1'b0;
		m = map_reg(s.start);
		w = 5'h00;
		j = s.cnt - POS_DATA;
		code = 8'h00;
		cause = CE_NONE;
		cmd = s.start + 16'h0001;
		rl = 8'h03;
		case (s.st)
			ST_RX: begin
				if (rx_err) begin
					next_s.st = ST_DROP;
				end else if (rx_valid) begin
					next_s.cnt = (s.cnt == 8'hff) ? s.cnt : s.cnt + 8'h01;
					case (s.cnt)
						8'h00: begin
							if (rx_data != slave_addr) begin
								next_s.st = ST_DROP;
							end
							next_s.shd = s.mem;
						end
						POS_FN: next_s.fn = rx_data;
						POS_START: next_s.start[15:8] = rx_data;
						POS_START + 8'h01: next_s.start[7:0] = rx_data;
						POS_QTY: next_s.qty[15:8] = rx_data;
						POS_QTY + 8'h01: next_s.qty[7:0] = rx_data;
						POS_BC: begin
							next_s.bc = rx_data;
							if (s.fn == FN_PRESET_MANY && s.start == NAME_BASE) begin
								for (int i = 0; i < 6; i++) begin
									next_s.shd[i] = SPACE_WORD;
								end
							end
						end
						default: ;
					endcase
					if (s.cnt == POS_DATA) begin
						next_s.first_bit = rx_data[0];
					end
					// Stage preset data; committed only after a good check.
					if (s.fn == FN_PRESET_MANY && s.cnt >= POS_DATA && j < s.bc) begin
						w = map_reg(s.start + {9'h000, j[7:1]});
						if (w[4] && w[3:0] < IDX_CMDERR) begin
							if (!j[0]) begin
								next_s.shd[w[3:0]][15:8] = rx_data;
							end else begin
								next_s.shd[w[3:0]][7:0] = rx_data;
							end
						end
					end
					if (s.cnt >= POS_START && s.cnt - POS_START < 8'(ECHO_LEN)) begin
						next_s.echo[s.cnt - POS_START] = rx_data;
					end
				end else if (rx_end) begin
					next_s.cnt = 8'h00;
					if (s.cnt >= MIN_FRAME && crc_rx == 16'h0000) begin
						case (s.fn)
							FN_RD_COIL, FN_RD_INPUT: begin
								if (s.qty == 16'h0000 || s.qty > MAX_BITS) begin
									code = EXC_VALUE;
									cause = CE_QTY;
								end else if (s.start >= MAX_BITS ||
									s.qty > MAX_BITS - s.start) begin
									code = EXC_ADDR;
								end
								rl = 8'h03 + 8'((s.qty + 16'h0007) >> 3);
							end
							FN_RD_HOLD: begin
								if (s.qty == 16'h0000 || s.qty > MAX_REGS) begin
									code = EXC_VALUE;
									cause = CE_QTY;
								end else if (!m[4]) begin
									code = EXC_ADDR;
								end
								rl = 8'h03 + {s.qty[6:0], 1'b0};
							end
							FN_FORCE_ONE, FN_FORCE_MANY: begin
								if (s.fn == FN_FORCE_ONE &&
									s.qty != COIL_ON && s.qty != COIL_OFF) begin
									code = EXC_VALUE;
									cause = CE_VALUE;
								end else if (s.fn == FN_FORCE_MANY &&
									(s.qty == 16'h0000 || s.qty > MAX_BITS)) begin
									code = EXC_VALUE;
									cause = CE_QTY;
								end else if (s.fn == FN_FORCE_MANY &&
									s.bc != 8'((s.qty + 16'h0007) >> 3)) begin
									code = EXC_VALUE;
									cause = CE_COUNT;
								end else if (cmd == CMD_EXIT && !s.remote) begin
									code = EXC_NAK;
									cause = CE_MODE;
								end
								rl = 8'h06;
							end
							FN_PRESET_ONE, FN_PRESET_MANY: begin
								if (s.fn == FN_PRESET_MANY &&
									(s.qty == 16'h0000 || s.qty > MAX_REGS)) begin
									code = EXC_VALUE;
									cause = CE_QTY;
								end else if (s.fn == FN_PRESET_MANY &&
									s.bc != {s.qty[6:0], 1'b0}) begin
									code = EXC_VALUE;
									cause = CE_COUNT;
								end else if (!m[4] || m[3:0] == IDX_CMDERR ||
									(m[3:0] < IDX_SETUP && s.start != NAME_BASE)) begin
									code = EXC_ADDR;
								end else if (m[3:0] >= IDX_SETUP && !s.remote) begin
									code = EXC_NAK;
									cause = CE_MODE;
								end
								rl = 8'h06;
							end
							FN_DIAG: begin
								if (s.start != DIAG_SUB) begin
									code = EXC_VALUE;
									cause = CE_SUBFN;
								end else if (s.cnt < POS_BC ||
									s.cnt - POS_BC > MAX_DIAG) begin
									code = EXC_VALUE;
									cause = CE_COUNT;
								end
								rl = s.cnt - 8'h02;
							end
							default: begin
								code = EXC_FUNC;
							end
						endcase
						if (code != 8'h00) begin
							rl = 8'h03;
							if (cause != CE_NONE) begin
								next_s.mem[IDX_CMDERR] = cause;
							end
						end else begin
							// Commit the query's effects.
							if (s.fn == FN_PRESET_MANY) begin
								next_s.mem = s.shd;
							end
							if (s.fn == FN_PRESET_ONE) begin
								if (m[3:0] < IDX_SETUP) begin
									for (int i = 0; i < 6; i++) begin
										next_s.mem[i] = SPACE_WORD;
									end
								end
								next_s.mem[m[3:0]] = s.qty;
							end
							if ((s.fn == FN_FORCE_ONE && s.qty == COIL_ON) ||
								(s.fn == FN_FORCE_MANY && s.first_bit)) begin
								next_s.cmd_valid = 1'b1;
								next_s.cmd_num = cmd;
								if (cmd == CMD_ENTER) begin
									next_s.remote = 1'b1;
								end else if (cmd == CMD_EXIT) begin
									next_s.remote = 1'b0;
								end
							end
						end
						next_s.exc = code;
						next_s.rlen = rl;
						next_s.ridx = 8'h00;
						next_s.tx_data = slave_addr;
						next_s.tx_valid = 1'b1;
						next_s.st = ST_RESP;
					end
				end
			end
			ST_DROP: begin
				// Wait out the rest of a frame that is not answered.
				if (rx_end) begin
					next_s.cnt = 8'h00;
					next_s.st = ST_RX;
				end
			end
			ST_RESP: begin
				if (tx_ready) begin
					next_s.ridx = s.ridx + 8'h01;
					if (s.ridx + 8'h01 == s.rlen) begin
						next_s.tx_valid = 1'b0;
						next_s.st = ST_GAP;
					end else begin
						next_s.tx_data = resp_byte(s.ridx + 8'h01);
					end
				end
			end
			ST_GAP: begin
				// The checksum of the last byte is ready one cycle later.
				next_s.tx_data = crc_tx[7:0];
				next_s.tx_valid = 1'b1;
				next_s.st = ST_CRCL;
			end
			ST_CRCL: begin
				if (tx_ready) begin
					next_s.tx_data = crc_tx[15:8];
					next_s.tx_last = 1'b1;
					next_s.st = ST_CRCH;
				end
			end
			ST_CRCH: begin
				if (tx_ready) begin
					next_s.tx_valid = 1'b0;
					next_s.tx_last = 1'b0;
					next_s.st = ST_RX;
				end
			end
			default: begin
				next_s.st = ST_RX;
			end
		endcase
		next_s.busy = (next_s.st != ST_RX) && (next_s.st != ST_DROP);
	end

	// Register the whole state.
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			s <= '0;
			s.mem <= MEM_RST;
		end else begin
			s <= next_s;
		end
	end

	// Outputs come straight from the state flops.
	assign tx_data      = s.tx_data;
	assign tx_valid     = s.tx_valid;
	assign tx_last      = s.tx_last;
	assign cmd_valid    = s.cmd_valid;
	assign cmd_num      = s.cmd_num;
	assign remote_setup = s.remote;
	assign busy         = s.busy;

endmodule

//--- modbus_query_pkg.sv
// Constants, types and the map of the Modbus slave query handler.
// Assumes a framing layer that delivers checked bytes and frame ends.

package modbus_query_pkg;

	// ------------------------------------------------------------
	// Function and exception codes
	// ------------------------------------------------------------
	localparam logic [7:0] FN_RD_COIL     = 8'h01;
	localparam logic [7:0] FN_RD_INPUT    = 8'h02;
	localparam logic [7:0] FN_RD_HOLD     = 8'h03;
	localparam logic [7:0] FN_FORCE_ONE   = 8'h05;
	localparam logic [7:0] FN_PRESET_ONE  = 8'h06;
	localparam logic [7:0] FN_DIAG        = 8'h08;
	localparam logic [7:0] FN_FORCE_MANY  = 8'h0f;
	localparam logic [7:0] FN_PRESET_MANY = 8'h10;
	localparam logic [7:0] EXC_FUNC       = 8'h01;
	localparam logic [7:0] EXC_ADDR       = 8'h02;
	localparam logic [7:0] EXC_VALUE      = 8'h03;
	localparam logic [7:0] EXC_NAK        = 8'h07;
	localparam logic [7:0] EXC_FLAG       = 8'h80;

	// ------------------------------------------------------------
	// Register map and reset values
	// ------------------------------------------------------------
	localparam logic [15:0] NAME_BASE   = 16'hae98;
	localparam logic [15:0] STR_REGS    = 16'h0006;
	localparam logic [15:0] NAME_END    = NAME_BASE + STR_REGS;
	localparam logic [15:0] SETUP_BASE  = 16'ha028;
	localparam logic [15:0] SETUP_END   = 16'ha02c;
	localparam logic [15:0] CMDERR_ADDR = 16'h9ca4;
	localparam int          NREG        = 11;
	localparam logic [3:0]  IDX_SETUP   = 4'h6;
	localparam logic [3:0]  IDX_CMDERR  = 4'ha;
	localparam logic [15:0] SPACE_WORD  = 16'h2020;
	localparam logic [15:0] FILLER      = 16'h0000;

	// ------------------------------------------------------------
	// Query limits, field positions and values
	// ------------------------------------------------------------
	localparam logic [15:0] MAX_BITS   = 16'h0010;
	localparam logic [15:0] MAX_REGS   = 16'h0064;
	localparam logic [7:0]  MAX_DIAG   = 8'h40;
	localparam int          ECHO_LEN   = 66;
	localparam logic [15:0] DIAG_SUB   = 16'h0000;
	localparam logic [15:0] COIL_ON    = 16'hff00;
	localparam logic [15:0] COIL_OFF   = 16'h0000;
	localparam logic [15:0] CMD_ENTER  = 16'h0064;
	localparam logic [15:0] CMD_EXIT   = 16'h0066;
	localparam logic [7:0]  POS_FN     = 8'h01;
	localparam logic [7:0]  POS_START  = 8'h02;
	localparam logic [7:0]  POS_QTY    = 8'h04;
	localparam logic [7:0]  POS_BC     = 8'h06;
	localparam logic [7:0]  POS_DATA   = 8'h07;
	localparam logic [7:0]  MIN_FRAME  = 8'h04;
	localparam logic [15:0] CRC_INIT   = 16'hffff;
	localparam logic [15:0] CRC_POLY   = 16'ha001;

	// Detailed causes kept in the command-error register.
	localparam logic [15:0] CE_NONE  = 16'h0000;
	localparam logic [15:0] CE_QTY   = 16'h0001;
	localparam logic [15:0] CE_VALUE = 16'h0002;
	localparam logic [15:0] CE_COUNT = 16'h0003;
	localparam logic [15:0] CE_MODE  = 16'h0004;
	localparam logic [15:0] CE_SUBFN = 16'h0005;

	typedef enum logic [2:0] {
		ST_RX   = 3'b000,
		ST_DROP = 3'b001,
		ST_RESP = 3'b010,
		ST_GAP  = 3'b011,
		ST_CRCL = 3'b100,
		ST_CRCH = 3'b101
	} st_t;

endpackage

//--- crc16_unit.sv
// Byte-wise CRC-16 accumulator, reflected polynomial.
// Assumes clr has priority over en; one byte per enabled clock.
`timescale 1ns/1ps
module crc16_unit #(
	parameter logic [15:0] POLY = 16'ha001,
	parameter logic [15:0] INIT = 16'hffff
) (
	// Clock and reset.
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	// Control and data.
	input  wire logic        clr,
	input  wire logic        en,
	input  wire logic [7:0]  din,
	// Running remainder.
	output logic      [15:0] crc
);

	logic [15:0] next_crc;

	// Fold one byte into the remainder, low bit first.
	always_comb begin
		next_crc = crc;
		if (clr) begin
			next_crc = INIT;
		end else if (en) begin
			next_crc = crc ^ {8'h00, din};
			for (int i = 0; i < 8; i++) begin
				if (next_crc[0]) begin
					next_crc = (next_crc >> 1) ^ POLY;
				end else begin
					next_crc = next_crc >> 1;
				end
			end
		end
	end

	// Hold the remainder.
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			crc <= INIT;
		end else begin
			crc <= next_crc;
		end
	end

endmodule

//--- modbus_query_checker.sv
// Checker for the Modbus slave query handler, bound to its top ports.
// Assumes one clock, ref_clk, and the synchronous active-low resetn.
`timescale 1ns/1ps
module modbus_query_checker (
	// Clock and reset.
	input wire logic       ref_clk,
	input wire logic       resetn,
	// Receive and transmit links.
	input wire logic       rx_err,
	input wire logic       rx_end,
	input wire logic       tx_ready,
	input wire logic [7:0] tx_data,
	input wire logic       tx_valid,
	input wire logic       tx_last,
	// Command and status.
	input wire logic       cmd_valid,
	input wire logic       remote_setup,
	input wire logic       busy
);
	default clocking cb @(posedge ref_clk); endclocking

	// ------------------------------------------------------------
	// Sequences
	// ------------------------------------------------------------
	// A frame flagged bad in its idle gap, then closed.
	sequence s_err_end;
		rx_err && !busy ##1 rx_end;
	endsequence
	// Last payload byte taken, then the gap before the checksum.
	sequence s_pdu_end;
		tx_valid && tx_ready && !tx_last ##1 !tx_valid && busy;
	endsequence

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_reset_quiet:
		assert property (!resetn |=> !tx_valid && !busy && !cmd_valid
			&& !remote_setup) else $error("outputs active after reset");
	a_drop_silent:
		assert property (disable iff (!resetn) s_err_end |=> !tx_valid[*2])
		else $error("reply to a flagged frame");
	a_reply_start:
		assert property (disable iff (!resetn)
			$rose(busy) |-> $past(rx_end) && tx_valid)
		else $error("reply not started by a frame end");
	a_tx_hold:
		assert property (disable iff (!resetn) tx_valid && !tx_ready |=>
			tx_valid && $stable(tx_data) && $stable(tx_last))
		else $error("reply byte changed while stalled");
	a_crc_gap:
		assert property (disable iff (!resetn)
			s_pdu_end |=> tx_valid && !tx_last)
		else $error("checksum low byte missing after gap");
	a_last_ends:
		assert property (disable iff (!resetn)
			tx_valid && tx_ready && tx_last |=> !tx_valid && !busy)
		else $error("reply continues after last byte");
	a_busy_cover:
		assert property (disable iff (!resetn) tx_valid |-> busy)
		else $error("reply byte while idle");
	a_cmd_pulse:
		assert property (disable iff (!resetn)
			cmd_valid |-> $past(rx_end) ##1 !cmd_valid)
		else $error("command pulse misplaced or too long");
	a_remote_cause:
		assert property (disable iff (!resetn) $changed(remote_setup) |->
			cmd_valid || $past(cmd_valid) || !$past(resetn))
		else $error("set-up state changed without command");
endmodule

bind modbus_slave_query_handler modbus_query_checker i_checker (
	.ref_clk(ref_clk), .resetn(resetn), .rx_err(rx_err),
	.rx_end(rx_end), .tx_ready(tx_ready), .tx_data(tx_data),
	.tx_valid(tx_valid), .tx_last(tx_last), .cmd_valid(cmd_valid),
	.remote_setup(remote_setup), .busy(busy));

//--- modbus_master_model.sv
// Model of the Modbus master: sends framed queries, collects replies.
// Assumes inputs change at the falling edge of ref_clk.
`timescale 1ns/1ps
module modbus_master_model (
	// Clock.
	input  wire logic       ref_clk,
	// Query bytes towards the slave.
	output logic      [7:0] rx_data,
	output logic            rx_valid,
	output logic            rx_end,
	output logic            rx_err,
	// Reply bytes from the slave.
	output logic            tx_ready,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	input  wire logic       tx_last
);
	import modbus_query_pkg::*;

	// Idle link at time zero.
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		rx_end = 1'b0;
		rx_err = 1'b0;
		tx_ready = 1'b1;
	end

	// Frame checksum, low byte sent first.
	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] c;
		c = CRC_INIT;
		foreach (b[i]) begin
			c = c ^ {8'h00, b[i]};
			for (int k = 0; k < 8; k++) begin
				c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
			end
		end
		return c;
	endfunction

	// Send one whole query, then wait a bounded time for the reply.
	task automatic query(input logic [7:0] q[$], input bit bad,
		input bit err, input bit slow, output logic [7:0] r[$]);
		logic [15:0] c;
		logic [7:0]  f[$];
		bit          done;
		c = crc16(q);
		f = q;
		f.push_back(c[7:0] ^ {7'h00, bad});
		f.push_back(c[15:8]);
		foreach (f[i]) begin
			@(negedge ref_clk);
			rx_data = f[i];
			rx_valid = 1'b1;
		end
		@(negedge ref_clk);
		rx_valid = 1'b0;
		rx_data = ~rx_data;
		rx_err = err;
		@(negedge ref_clk);
		rx_err = 1'b0;
		rx_end = 1'b1;
		@(negedge ref_clk);
		rx_end = 1'b0;
		r = {};
		done = 1'b0;
		// A corrupted query never gets an answer, so give up in time.
		for (int n = 0; n < 200 && !done; n++) begin
			tx_ready = slow ? ~tx_ready : 1'b1;
			#1;
			if (tx_valid === 1'b1 && tx_ready) begin
				r.push_back(tx_data);
				done = tx_last;
			end
			@(negedge ref_clk);
		end
		// Strip a good checksum; a bad one spoils the whole reply.
		if (r.size() > 2) begin
			f = r[0:r.size()-3];
			c = crc16(f);
			if (c !== {r[r.size()-1], r[r.size()-2]}) r = {};
			else r = f;
		end
	endtask
endmodule

//--- tb_modbus_slave_query_handler.sv
// Testbench of the Modbus slave query handler with a master model.
// Assumes the checker file is compiled alongside for its bind.
`timescale 1ns/1ps
module tb_modbus_slave_query_handler;
	import modbus_query_pkg::*;
	localparam logic [7:0] ADDR = 8'h11;
	logic        ref_clk = 1'b0;
	logic        resetn = 1'b0;
	logic [7:0]  rx_data, tx_data;
	logic        rx_valid, rx_end, rx_err, tx_ready, tx_valid, tx_last;
	logic        cmd_valid, remote_setup, busy;
	logic [15:0] cmd_num;
	int          n_fail, cmp_count, n_cmd;
	logic [7:0]  got[$], exp[$];

	always #12.5 ref_clk = ~ref_clk;

	modbus_slave_query_handler i_dut (.ref_clk(ref_clk),
		.resetn(resetn), .slave_addr(ADDR), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_end(rx_end), .rx_err(rx_err),
		.tx_ready(tx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_last(tx_last), .cmd_valid(cmd_valid), .cmd_num(cmd_num),
		.remote_setup(remote_setup), .busy(busy));
	modbus_master_model i_master (.ref_clk(ref_clk), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_end(rx_end), .rx_err(rx_err),
		.tx_ready(tx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_last(tx_last));

	// Count command pulses as the slave issues them.
	always @(posedge ref_clk) begin
		if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
	end

	// Compare one value, report and count.
	task automatic chk(input logic [15:0] g, input logic [15:0] e,
		input string what);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: %s %h not %h", $time, what, g, e);
		end
	endtask
	// Send one query and compare the reply without its checksum.
	task automatic xfer(input logic [7:0] q[$], input bit bad,
		input bit err, input bit slow);
		i_master.query(q, bad, err, slow, got);
		chk(16'(got.size()), 16'(exp.size()), "reply length");
		foreach (exp[i]) begin
			if (i < got.size()) begin
				chk({8'h00, got[i]}, {8'h00, exp[i]}, "reply byte");
			end
		end
		chk({15'h0000, busy}, 16'h0000, "busy after reply");
	endtask

	// Name string: reset spaces, partial writes, reads from the middle.
	task automatic t_strings();
		exp = {ADDR, FN_RD_HOLD, 8'h02, SPACE_WORD[15:8], SPACE_WORD[7:0]};
		xfer({ADDR, FN_RD_HOLD, 8'hae, 8'h98, 8'h00, 8'h01}, 0, 0, 0);
		exp = {ADDR, FN_PRESET_MANY, 8'hae, 8'h98, 8'h00, 8'h02};
		xfer({exp, 8'h04, 8'h41, 8'h42, 8'h43, 8'h44}, 0, 0, 0);
		exp = {ADDR, FN_RD_HOLD, 8'h0c, 8'h43, 8'h44};
		repeat (8) exp.push_back(8'h20);
		exp = {exp, FILLER[15:8], FILLER[7:0]};
		xfer({ADDR, FN_RD_HOLD, 8'hae, 8'h99, 8'h00, 8'h06}, 0, 0, 0);
		exp = {ADDR, FN_PRESET_ONE, 8'hae, 8'h98, 8'h58, 8'h59};
		xfer(exp, 0, 0, 0);
		exp = {ADDR, FN_RD_HOLD, 8'h0c, 8'h58, 8'h59};
		repeat (10) exp.push_back(8'h20);
		xfer({ADDR, FN_RD_HOLD, 8'hae, 8'h98, 8'h00, 8'h06}, 0, 0, 1);
	endtask

	// Every exception code, then the recorded cause.
	task automatic t_except();
		logic [47:0] rows [8];
		logic [7:0]  q[$];
		rows = '{48'h04_0000_0001_01, 48'h03_0000_0001_02,
			48'h01_0000_0011_03, 48'h06_a028_0007_07,
			48'h06_ae99_4142_02, 48'h06_9ca4_0001_02,
			48'h03_ae98_0065_03, 48'h08_0001_0000_03};
		foreach (rows[i]) begin
			q = {ADDR, rows[i][47:40], rows[i][39:32], rows[i][31:24],
				rows[i][23:16], rows[i][15:8]};
			exp = {ADDR, rows[i][47:40] | EXC_FLAG, rows[i][7:0]};
			xfer(q, 0, 0, 0);
		end
		exp = {ADDR, FN_RD_HOLD, 8'h02, CE_SUBFN[15:8], CE_SUBFN[7:0]};
		xfer({ADDR, FN_RD_HOLD, 8'h9c, 8'ha4, 8'h00, 8'h01}, 0, 0, 0);
	endtask

	// Point reads, coil commands and set-up writes in remote state.
	task automatic t_coils();
		int n0;
		logic [7:0] q[$];
		for (int f = 1; f <= 2; f++) begin
			exp = {ADDR, 8'(f), 8'h02, 8'h00, 8'h00};
			xfer({ADDR, 8'(f), 8'h00, 8'h00, 8'h00, 8'h10}, 0, 0, 0);
		end
		n0 = n_cmd;
		exp = {ADDR, FN_FORCE_ONE, 8'h00, 8'h63, COIL_ON[15:8], 8'h00};
		xfer(exp, 0, 0, 0);
		chk(16'(n_cmd - n0), 16'h0001, "command count");
		chk(cmd_num, 16'h0064, "command number");
		chk({15'h0000, remote_setup}, 16'h0001, "remote state");
		exp = {ADDR, FN_FORCE_ONE, 8'h00, 8'h63, 8'h00, 8'h00};
		xfer(exp, 0, 0, 0);
		chk(16'(n_cmd - n0), 16'h0001, "command count");
		exp = {ADDR, FN_PRESET_ONE, 8'ha0, 8'h28, 8'h00, 8'h07};
		xfer(exp, 0, 0, 0);
		exp = {ADDR, FN_RD_HOLD, 8'h02, 8'h00, 8'h07};
		xfer({ADDR, FN_RD_HOLD, 8'ha0, 8'h28, 8'h00, 8'h01}, 0, 0, 0);
		exp = {ADDR, FN_FORCE_MANY, 8'h00, 8'h65, 8'h00, 8'h02};
		xfer({exp, 8'h01, 8'h03}, 0, 0, 0);
		chk(16'(n_cmd - n0), 16'h0002, "command count");
		chk(cmd_num, 16'h0066, "command number");
		chk({15'h0000, remote_setup}, 16'h0000, "remote state");
		// Leaving set-up while not in it is refused and the cause is kept.
		q = {ADDR, FN_FORCE_ONE, 8'h00, 8'h65, COIL_ON[15:8], 8'h00};
		exp = {ADDR, FN_FORCE_ONE | EXC_FLAG, EXC_NAK};
		xfer(q, 0, 0, 0);
		chk(16'(n_cmd - n0), 16'h0002, "command count");
		chk({15'h0000, remote_setup}, 16'h0000, "remote state");
		exp = {ADDR, FN_RD_HOLD, 8'h02, CE_MODE[15:8], CE_MODE[7:0]};
		xfer({ADDR, FN_RD_HOLD, 8'h9c, 8'ha4, 8'h00, 8'h01}, 0, 0, 0);
	endtask

	// Loop-back echo, then dropped frames and recovery with stalls.
	task automatic t_link();
		logic [7:0] q[$];
		exp = {ADDR, FN_DIAG, 8'h00, 8'h00, 8'hde, 8'had, 8'hbe, 8'hef};
		xfer(exp, 0, 0, 1);
		q = {ADDR, FN_RD_HOLD, 8'hae, 8'h98, 8'h00, 8'h01};
		exp = {};
		xfer(q, 1, 0, 0);
		xfer(q, 0, 1, 0);
		xfer({8'h00, q[1:5]}, 0, 0, 0);
		exp = {ADDR, FN_RD_HOLD, 8'h02, 8'h58, 8'h59};
		xfer(q, 0, 0, 1);
	endtask

	// Print the counts and the verdict, then stop.
	task automatic final_report();
		$display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Main sequence after a ten-cycle reset.
	initial begin
		repeat (10) @(negedge ref_clk);
		resetn = 1'b1;
		t_strings();
		t_except();
		t_coils();
		t_link();
		final_report();
	end

	// Watchdog well beyond the expected run length.
	initial begin
		repeat (30000) @(posedge ref_clk);
		n_fail++;
		final_report();
	end
endmodule
